// File: verilog/link_selftest_pkg.sv
`default_nettype none
package link_selftest_pkg;
  // Word-aligned byte offsets of the register map
  localparam logic [11:0] CTRL_LO_OFS  = 12'h1a0;
  localparam logic [11:0] STORE_LO_OFS = 12'h1a4;
  localparam logic [11:0] MASK_LO_OFS  = 12'h1a8;
  localparam logic [11:0] RUN_OFS      = 12'h1b0;
  localparam logic [11:0] CTRL_HI_OFS  = 12'h2a0;
  localparam logic [11:0] STORE_HI_OFS = 12'h2a4;
  localparam logic [11:0] MASK_HI_OFS  = 12'h2a8;
  // Control field positions
  localparam int LOOP_LSB   = 26;
  localparam int CONST_LSB  = 21;
  localparam int CSET_BIT   = 20;
  localparam int TOG_LSB    = 13;
  localparam int PER_LSB    = 10;
  localparam int STORE_LSB  = 3;
  localparam int ORDER_LSB  = 0;
  // Run register bit positions
  localparam int RUN_START_BIT = 0;
  localparam int RUN_PORT_BIT  = 1;
  localparam int RUN_BUSY_BIT  = 8;
  // Values after reset
  localparam logic [31:0] CTRL_RST  = {6'h04, 5'h00, 1'b0, 7'h19, 3'h1, 7'h19, 3'h0};
  localparam logic [23:0] STORE_RST = 24'h02ccfd;
  localparam logic [9:0]  DMASK_RST = 10'h3ff;
  localparam logic [3:0]  TMASK_RST = 4'hf;
  // Periodic words of the toggle section
  localparam logic [23:0] TOG_P2  = 24'h555555;
  localparam logic [23:0] TOG_P4  = 24'h333333;
  localparam logic [23:0] TOG_P6  = 24'h1c71c7;
  localparam logic [23:0] TOG_P8  = 24'h0f0f0f;
  localparam logic [23:0] TOG_P12 = 24'h000fff;
  // Section kinds
  typedef enum logic [1:0] {SEC_STORE, SEC_TOGGLE, SEC_CONST} sect_t;
  // One beat of test payload toward the link
  typedef struct packed {
    logic [23:0] frame;        // One 24-bit count unit
    logic        secondFrame;  // High on second frame of a transfer
    logic [13:0] invertLanes;  // Lanes that send the pattern inverted
    sect_t       section;      // Section that made this frame
  } beat_t;
endpackage
`default_nettype wire

// File: verilog/link_selftest_pattern_gen.sv
// Function
// - Overall loop count; zero sends nothing.
// - Constant repeat count; zero disables constant.
// - Constant section emits zeros or ones.
// - Toggle repeat count of 24-bit units.
// - Toggle period code picks periodic word.
// - Store repeat count; zero disables store.
// - Transfer is two frames, 24 bits each.
// - Order code picks one of six permutations.
// - Second store holds 24 bits, resets 02ccfd.
// - Ten data-lane masks, all set at reset.
// - Four test-lane masks, all set at reset.
// - Masked lanes send inverted pattern during run.
`timescale 1ns/100ps
`default_nettype none
module link_selftest_pattern_gen
  import link_selftest_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [11:0]              adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  output link_selftest_pkg::beat_t      outData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic                          runActive
);
  import link_selftest_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_EMIT} state_t;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // Section at a slot for a given order code
  function automatic sect_t order_sect(input logic [2:0] ord, input logic [1:0] slot);
    logic [5:0] seq;
    case (ord)
      3'h1:    seq = {SEC_STORE, SEC_CONST, SEC_TOGGLE};
      3'h2:    seq = {SEC_TOGGLE, SEC_STORE, SEC_CONST};
      3'h3:    seq = {SEC_TOGGLE, SEC_CONST, SEC_STORE};
      3'h4:    seq = {SEC_CONST, SEC_STORE, SEC_TOGGLE};
      3'h5:    seq = {SEC_CONST, SEC_TOGGLE, SEC_STORE};
      default: seq = {SEC_STORE, SEC_TOGGLE, SEC_CONST}; // Reserved codes act as 000
    endcase
    case (slot)
      2'h0:    order_sect = sect_t'(seq[5:4]);
      2'h1:    order_sect = sect_t'(seq[3:2]);
      default: order_sect = sect_t'(seq[1:0]);
    endcase
  endfunction

  // Periodic word for a toggle period code
  function automatic logic [23:0] toggle_word(input logic [2:0] code);
    case (code)
      3'h1:    toggle_word = TOG_P2;
      3'h2:    toggle_word = TOG_P4;
      3'h3:    toggle_word = TOG_P6;
      3'h4:    toggle_word = TOG_P8;
      3'h6:    toggle_word = TOG_P12;
      default: toggle_word = 24'h000000; // Undefined codes stay quiet
    endcase
  endfunction

  logic [31:0] ctrlQ [2];      // Generator control, per port
  logic [23:0] storeQ [2];     // Second pattern store, per port
  logic [13:0] maskQ [2];      // Test lanes over data lanes, per port
  logic        portSelQ;       // Port chosen for the next run
  logic        ackQ;           // Bus answer
  logic [31:0] datQ;           // Read data held with the answer
  state_t      stateQ;         // Sequencer state
  logic        runQ;           // Run in progress
  logic        portQ;          // Port latched at run start
  logic [5:0]  loopLeftQ;      // Passes still to go
  logic [1:0]  slotQ;          // Position in the section order
  logic [6:0]  repLeftQ;       // Units left in this section
  logic        frameHalfQ;     // Which frame of a transfer is next
  beat_t       outQ;           // Buffer head, drives the link side
  logic        outValidQ;      // Head holds a beat
  beat_t       skidQ;          // Second buffer entry
  logic        skidValidQ;     // Second entry holds a beat

  // Bus decode
  logic        wbReq;          // Request waiting for an answer
  logic        wrHit;          // Write taken at the answer edge
  logic [31:0] rdWord;         // Current value at the address
  logic [31:0] wrWord;         // Byte-merged write value
  logic        startPulse;     // Software start
  logic        startPort;      // Port named by the start write itself

  assign wbReq = cyc_i & stb_i & ~ackQ;
  assign wrHit = cyc_i & stb_i & we_i & ackQ;
  assign wrWord = merge(rdWord, dat_i, sel_i);
  assign startPulse = wrHit && (adr_i[11:2] == RUN_OFS[11:2]) && sel_i[0]
                      && dat_i[RUN_START_BIT];
  // Taken from the write, not the register, so one write can switch port and start
  assign startPort = wrWord[RUN_PORT_BIT];

  // Read view; reserved bits and unmapped words read as zero
  always_comb begin
    case (adr_i[11:2])
      CTRL_LO_OFS[11:2]:  rdWord = ctrlQ[0];
      CTRL_HI_OFS[11:2]:  rdWord = ctrlQ[1];
      STORE_LO_OFS[11:2]: rdWord = {8'h00, storeQ[0]};
      STORE_HI_OFS[11:2]: rdWord = {8'h00, storeQ[1]};
      MASK_LO_OFS[11:2]:  rdWord = {18'h00000, maskQ[0]};
      MASK_HI_OFS[11:2]:  rdWord = {18'h00000, maskQ[1]};
      RUN_OFS[11:2]:      rdWord = {23'h000000, runQ, 6'h00, portSelQ, 1'b0};
      default:            rdWord = 32'h00000000;
    endcase
  end

  // Answer every request after one cycle, mapped or not
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackQ <= 1'b0;
      datQ <= 32'h00000000;
    end else begin
      ackQ <= wbReq;
      if (wbReq) begin
        datQ <= rdWord;
      end
    end
  end
  assign ack_o = ackQ;
  assign dat_o = datQ;

  // Register writes land on the edge the master sees the answer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlQ[0]  <= CTRL_RST;
      ctrlQ[1]  <= CTRL_RST;
      storeQ[0] <= STORE_RST;
      storeQ[1] <= STORE_RST;
      maskQ[0]  <= {TMASK_RST, DMASK_RST};
      maskQ[1]  <= {TMASK_RST, DMASK_RST};
      portSelQ  <= 1'b0;
    end else if (wrHit) begin
      case (adr_i[11:2])
        CTRL_LO_OFS[11:2]:  ctrlQ[0] <= wrWord;
        CTRL_HI_OFS[11:2]:  ctrlQ[1] <= wrWord;
        STORE_LO_OFS[11:2]: storeQ[0] <= wrWord[23:0];
        STORE_HI_OFS[11:2]: storeQ[1] <= wrWord[23:0];
        MASK_LO_OFS[11:2]:  maskQ[0] <= wrWord[13:0];
        MASK_HI_OFS[11:2]:  maskQ[1] <= wrWord[13:0];
        RUN_OFS[11:2]:      portSelQ <= wrWord[RUN_PORT_BIT];
        default:            ;
      endcase
    end
  end

  // Live view of the running port's fields; edits during a run take effect at once, but the loop count is latched at start and a section count at its seek
  logic [31:0] cfg;            // Control of the active port
  sect_t       sect;           // Section at the current slot
  logic [6:0]  secCount;       // Repeat count of that section
  logic        pushReady;      // Buffer can take a beat
  logic        push;           // Beat enters the buffer
  beat_t       pushData;       // Beat being offered
  logic        advance;        // Leave the current section
  logic        lastStep;       // Advance ends the run

  assign cfg = ctrlQ[portQ];
  assign sect = order_sect(cfg[ORDER_LSB +: 3], slotQ);

  // Repeat count per section, widened to seven bits
  always_comb begin
    case (sect)
      SEC_STORE:  secCount = cfg[STORE_LSB +: 7];
      SEC_TOGGLE: secCount = cfg[TOG_LSB +: 7];
      SEC_CONST:  secCount = {2'b00, cfg[CONST_LSB +: 5]};
      default:    secCount = 7'h00;
    endcase
  end

  // Frame content of the current section
  always_comb begin
    pushData.secondFrame = frameHalfQ;
    pushData.invertLanes = maskQ[portQ];
    pushData.section     = sect;
    case (sect)
      SEC_STORE:  pushData.frame = storeQ[portQ];
      SEC_TOGGLE: pushData.frame = toggle_word(cfg[PER_LSB +: 3]);
      SEC_CONST:  pushData.frame = {24{cfg[CSET_BIT]}};
      default:    pushData.frame = 24'h000000;
    endcase
  end

  assign pushReady = ~skidValidQ;
  assign push = (stateQ == ST_EMIT) && pushReady;
  // Empty sections pass straight on in the seek cycle
  assign advance = ((stateQ == ST_SEEK) && (secCount == 7'h00))
                   || (push && (repLeftQ == 7'h01));
  assign lastStep = (slotQ == 2'h2) && (loopLeftQ == 6'h01);

  // Sequencer over loops, slots and repeats
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ     <= ST_IDLE;
      runQ       <= 1'b0;
      portQ      <= 1'b0;
      loopLeftQ  <= 6'h00;
      slotQ      <= 2'h0;
      repLeftQ   <= 7'h00;
      frameHalfQ <= 1'b0;
    end else begin
      if (push) begin
        frameHalfQ <= ~frameHalfQ;
      end
      if (advance) begin
        if (lastStep) begin
          stateQ <= ST_IDLE;
          runQ   <= 1'b0;
        end else if (slotQ == 2'h2) begin
          loopLeftQ <= loopLeftQ - 6'h01;
          slotQ     <= 2'h0;
          stateQ    <= ST_SEEK;
        end else begin
          slotQ  <= slotQ + 2'h1;
          stateQ <= ST_SEEK;
        end
      end else begin
        case (stateQ)
          ST_IDLE: begin
            // A zero loop count leaves the payload empty
            if (startPulse && (ctrlQ[startPort][LOOP_LSB +: 6] != 6'h00)) begin
              portQ      <= startPort;
              loopLeftQ  <= ctrlQ[startPort][LOOP_LSB +: 6];
              slotQ      <= 2'h0;
              frameHalfQ <= 1'b0;
              runQ       <= 1'b1;
              stateQ     <= ST_SEEK;
            end
          end
          ST_SEEK: begin
            repLeftQ <= secCount;
            stateQ   <= ST_EMIT;
          end
          ST_EMIT: begin
            if (push) begin
              repLeftQ <= repLeftQ - 7'h01;
            end
          end
          default: stateQ <= ST_IDLE;
        endcase
      end
    end
  end
  assign runActive = runQ;

  // Two-entry buffer: the skid entry catches a beat when the link stalls
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      outQ       <= '0;
      outValidQ  <= 1'b0;
      skidQ      <= '0;
      skidValidQ <= 1'b0;
    end else if (outReady || !outValidQ) begin
      if (skidValidQ) begin
        outQ       <= skidQ;
        outValidQ  <= 1'b1;
        skidValidQ <= 1'b0;
      end else begin
        outQ      <= pushData;
        outValidQ <= push;
      end
    end else if (push) begin
      skidQ      <= pushData;
      skidValidQ <= 1'b1;
    end
  end
  assign outData  = outQ;
  assign outValid = outValidQ;

  // Helper: beats pushed in the current section
  logic [6:0] secPushes;       // Count of beats this section
  logic [6:0] secTarget;       // Count loaded at seek
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      secPushes <= 7'h00;
      secTarget <= 7'h00;
    end else if (stateQ == ST_SEEK) begin
      secPushes <= 7'h00;
      secTarget <= secCount;
    end else if (push) begin
      secPushes <= secPushes + 7'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence sStall;
    outValidQ && !outReady;
  endsequence
  sequence sHeld;
    outValidQ && $stable(outQ);
  endsequence

  a_ack_single_pulse: assert property (ackQ |=> !ackQ)
    else $error("bus answer lasted more than one cycle");
  a_zero_loop_idle: assert property (
    (stateQ == ST_IDLE) && startPulse && (ctrlQ[startPort][LOOP_LSB +: 6] == 6'h00)
    |=> ((stateQ == ST_IDLE) && !runQ) [*2])
    else $error("run started with zero loop count");
  a_section_count: assert property (
    (stateQ == ST_EMIT) && advance |-> (secPushes + 7'h01) == secTarget)
    else $error("section emitted wrong number of frames");
  a_skip_empty: assert property (
    (stateQ == ST_SEEK) && (secCount == 7'h00) |=> (stateQ != ST_EMIT))
    else $error("empty section emitted frames");
  a_const_value: assert property (
    outValidQ && (outQ.section == SEC_CONST) && !$changed(ctrlQ[portQ])
    |-> (outQ.frame == 24'h000000) || (outQ.frame == 24'hffffff))
    else $error("constant frame not all zeros or ones");
  a_toggle_word: assert property (
    push && (sect == SEC_TOGGLE) && (cfg[PER_LSB +: 3] == 3'h2)
    |-> pushData.frame == 24'h333333)
    else $error("toggle period code gave wrong word");
  a_order_first: assert property (
    (stateQ == ST_SEEK) && (slotQ == 2'h0) && (cfg[ORDER_LSB +: 3] == 3'h4)
    |-> sect == SEC_CONST)
    else $error("order code put wrong section first");
  a_frame_pair: assert property (
    push ##1 (stateQ == ST_EMIT) && push |-> pushData.secondFrame != $past(frameHalfQ))
    else $error("frames of a transfer did not alternate");
  a_invert_lanes: assert property (
    push |-> runQ && (pushData.invertLanes == maskQ[portQ]))
    else $error("inversion lanes do not follow the mask");
  a_buffer_hold: assert property (sStall |=> sHeld)
    else $error("stalled beat changed or vanished");

endmodule // link_selftest_pattern_gen
`default_nettype wire

// File: tb/stream_sink.sv
`timescale 1ns/100ps
`default_nettype none
// Far-end receiver: takes beats, optionally stalls at random
module stream_sink
  import link_selftest_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire link_selftest_pkg::beat_t inData,
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic                     stallOn
);
  beat_t got[$];  // Beats taken, in arrival order
  // Take on handshake; ready drawn anew each cycle so stalls hit any phase
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      inReady <= 1'b0;
    end else begin
      if (inValid && inReady) begin
        got.push_back(inData);
      end
      inReady <= stallOn ? ($urandom % 3 == 0) : 1'b1;
    end
  end
endmodule // stream_sink
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import link_selftest_pkg::*;
  logic        ref_clk = 1'b0;  // 50 MHz
  logic        reset_n = 1'b0;  // Async, active low
  logic        cyc = 1'b0;      // Bus cycle
  logic        stb = 1'b0;      // Bus strobe
  logic        we = 1'b0;       // Write enable
  logic [11:0] adr = '0;        // Byte address
  logic [3:0]  sel = 4'hf;      // Byte enables
  logic [31:0] wdat = '0;       // Write data
  logic [31:0] rdat;            // Read data
  logic        ack;             // Bus answer
  beat_t       beat;            // Payload beat
  logic        bValid;          // Beat valid
  logic        bReady;          // Beat taken
  logic        runActive;       // Run in progress
  logic        stall = 1'b0;    // Receiver stalls at random
  int          num_errors = 0;
  int          cmp_count = 0;
  beat_t       expQ[$];         // Expected stream
  always #10 ref_clk = ~ref_clk;
  link_selftest_pattern_gen dut (.ref_clk(ref_clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .outData(beat), .outValid(bValid), .outReady(bReady), .runActive(runActive));
  stream_sink sink (.ref_clk(ref_clk), .reset_n(reset_n), .inData(beat), .inValid(bValid),
    .inReady(bReady), .stallOn(stall));
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBeat(input int idx, input beat_t exp, input beat_t got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch beat %0d expected %h seen %h", idx, exp, got);
    end
  endtask
  // Classic single cycle; hold until ack sampled high, bounded wait
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("mismatch ack expected 1 seen %b", ack);
      close_out();
    end
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // Periodic toggle words worked out from the period codes
  function automatic logic [23:0] togWord(input logic [2:0] pc);
    case (pc)
      3'h1: return 24'h555555;
      3'h2: return 24'h333333;
      3'h3: return 24'h1c71c7;
      3'h4: return 24'h0f0f0f;
      3'h6: return 24'h000fff;
      default: return 24'h000000;
    endcase
  endfunction
  // Section order, slot 0 in the top pair; reserved codes run as 000
  function automatic logic [5:0] perm(input logic [2:0] oc);
    case (oc)
      3'h1: return 6'b00_10_01;
      3'h2: return 6'b01_00_10;
      3'h3: return 6'b01_10_00;
      3'h4: return 6'b10_00_01;
      3'h5: return 6'b10_01_00;
      default: return 6'b00_01_10;
    endcase
  endfunction
  // Program one port, predict the stream, start, drain and compare
  task automatic run(input logic [5:0] lp, input logic [4:0] cc, input logic cs,
                     input logic [6:0] tc, input logic [2:0] pc, input logic [6:0] sc,
                     input logic [2:0] oc, input logic port, input logic [23:0] st,
                     input logic [13:0] mk);
    logic [31:0] rd;
    logic [11:0] base;
    int          cnt[3];
    sect_t       s;
    int          n;
    logic [23:0] fr;
    base = port ? 12'h200 : 12'h100;
    cnt = '{sc, tc, cc};
    wb(1'b1, base + 12'h0a0, {lp, cc, cs, tc, pc, sc, oc}, rd);
    wb(1'b1, base + 12'h0a4, {8'ha5, st}, rd);
    wb(1'b0, base + 12'h0a4, 32'h0, rd);
    check("store readback", {8'h00, st}, rd);
    wb(1'b1, base + 12'h0a8, {18'h3ffff, mk}, rd);
    wb(1'b0, base + 12'h0a8, 32'h0, rd);
    check("mask readback", {18'h0, mk}, rd);
    expQ.delete();
    for (int l = 0; l < lp; l++) begin
      for (int k = 0; k < 3; k++) begin
        s = sect_t'(2'(perm(oc) >> (4 - 2 * k)));
        fr = (s == SEC_STORE) ? st : (s == SEC_TOGGLE) ? togWord(pc) : {24{cs}};
        for (int j = 0; j < cnt[s]; j++) begin
          expQ.push_back(beat_t'{fr, 1'(expQ.size() % 2), mk, s});
        end
      end
    end
    sink.got.delete();
    wb(1'b1, RUN_OFS, {30'h0, port, 1'b1}, rd);
    repeat (2) @(posedge ref_clk);
    check("runActive", {31'h0, lp != 0}, {31'h0, runActive});
    n = 0;
    while ((runActive !== 1'b0 || bValid !== 1'b0) && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      $display("mismatch drain expected idle seen busy");
      close_out();
    end
    repeat (2) @(posedge ref_clk);
    check("beat count", expQ.size(), sink.got.size());
    for (int i = 0; i < expQ.size() && i < sink.got.size(); i++) begin
      checkBeat(i, expQ[i], sink.got[i]);
    end
    $display("test run order %0d loop %0d done", oc, lp);
  endtask
  // Main sequence
  initial begin
    logic [11:0] rAdr[8];
    logic [31:0] rVal[8];
    logic [31:0] rd;
    logic [31:0] ctrlRst;
    ctrlRst = {6'h04, 5'h00, 1'b0, 7'h19, 3'h1, 7'h19, 3'h0};
    rAdr = '{12'h1a0, 12'h1a4, 12'h1a8, 12'h2a0, 12'h2a4, 12'h2a8, RUN_OFS, 12'h3f0};
    rVal = '{ctrlRst, 32'h02ccfd, 32'h3fff, ctrlRst, 32'h02ccfd, 32'h3fff, 32'h0, 32'h0};
    void'($urandom(91));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Values after reset, unmapped place included
    wb(1'b1, 12'h3f0, 32'hffffffff, rd);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, rAdr[i], 32'h0, rd);
      check("reset value", rVal[i], rd);
    end
    $display("test reset values done");
    // Loop count zero sends nothing
    run(6'h00, 5'h01, 1'b1, 7'h01, 3'h1, 7'h01, 3'h0, 1'b0, 24'h123456, 14'h0155);
    // Every order and period code, random counts, ports and stalls
    for (int i = 0; i < 16; i++) begin
      stall <= 1'($urandom % 2);
      run(6'(1 + $urandom % 3), 5'($urandom % 4), i[0], 7'($urandom % 4), 3'(i % 8),
          7'($urandom % 4), 3'(i % 8), 1'($urandom % 2), 24'($urandom), 14'($urandom));
    end
    // Corners: all sections off, then full-size counts under stall
    run(6'h03, 5'h00, 1'b0, 7'h00, 3'h1, 7'h00, 3'h2, 1'b1, 24'h0f00f0, 14'h2aaa);
    stall <= 1'b1;
    run(6'h01, 5'h1f, 1'b1, 7'h7f, 3'h6, 7'h7f, 3'h5, 1'b0, 24'hc3a5e1, 14'h3c0f);
    close_out();
  end
endmodule // tb
`default_nettype wire
